/* hdl/pmr_defines.vh */
// Constants for the power meter result and mode register bank.
// Included by pmr_regs.v; holds definitions only.
`ifndef PMR_DEFINES_VH
`define PMR_DEFINES_VH

// Register indices on the serial register port.
`define PMR_ADDR_IOFF    5'h10
`define PMR_ADDR_VOFF    5'h11
`define PMR_ADDR_MODE    5'h12
`define PMR_ADDR_TEMP    5'h13
`define PMR_ADDR_QMEAN   5'h14
`define PMR_ADDR_QINST   5'h15
`define PMR_ADDR_IPEAK   5'h16
`define PMR_ADDR_VPEAK   5'h17
`define PMR_ADDR_QROOT   5'h18
`define PMR_ADDR_PFAC    5'h19
`define PMR_ADDR_SAPP    5'h1B
`define PMR_ADDR_STATUS  5'h0F

// Reset values.
`define PMR_RST_OFFSET   24'h000000
`define PMR_RST_MODE     24'h000000
`define PMR_RST_RESULT   24'h000000

// Mode register field positions and writable mask.
`define PMR_MODE_MASK    24'h0003FF
`define PMR_BIT_E2SEL    9
`define PMR_BIT_VDLY     8
`define PMR_BIT_IDLY     7
`define PMR_BIT_IHP      6
`define PMR_BIT_VHP      5
`define PMR_BIT_CBYP     4
`define PMR_BIT_E3HI     3
`define PMR_BIT_E3LO     2
`define PMR_BIT_POS      1
`define PMR_BIT_FTRK     0

// Status bit of the computation-done flag.
`define PMR_BIT_DONE     23

// Calibration length: CAL_MUL * N + CAL_ADD conversions.
`define PMR_CAL_MUL      27'd6
`define PMR_CAL_ADD      27'd30

// Iteration counts of the shared arithmetic engine.
`define PMR_DIV_STEPS    6'd48
`define PMR_SQRT_STEPS   6'd24

`endif

/* hdl/pmr_regs.v */
// Result and operating-mode registers of a single-phase power meter.
// Assumes a serial protocol engine and the measurement chain on CLOCK.
`timescale 1ns/100ps
`default_nettype none
`include "pmr_defines.vh"

module pmr_regs (
  input  wire        CLOCK,
  input  wire        RESET_N,
  input  wire [4:0]  REG_ADDR,
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [23:0] REG_WDATA,
  output wire [23:0] REG_RDATA,
  input  wire        SAMPLE_VALID,
  input  wire        CONVERTING,
  input  wire [23:0] CYCLE_COUNT,
  input  wire [23:0] I_SAMPLE,
  input  wire [23:0] V_SAMPLE,
  input  wire [23:0] V_QUAD_SAMPLE,
  input  wire        TEMP_VALID,
  input  wire [23:0] TEMP_SAMPLE,
  input  wire [23:0] P_ACTIVE,
  input  wire [23:0] I_RMS,
  input  wire [23:0] V_RMS,
  input  wire        CAL_START,
  input  wire        ENERGY_PULSE_IN,
  input  wire        ENERGY_NEGATIVE,
  input  wire        APPARENT_PULSE_IN,
  input  wire        REACTIVE_PULSE_IN,
  input  wire        VOLTAGE_SIGN,
  input  wire        SUPPLY_MONITOR_INPUT,
  output wire [23:0] I_PATH_OUT,
  output wire [23:0] V_PATH_OUT,
  output wire        CURRENT_HIGHPASS_ENABLE,
  output wire        VOLTAGE_HIGHPASS_ENABLE,
  output wire        CURRENT_ALLPASS_ENABLE,
  output wire        VOLTAGE_ALLPASS_ENABLE,
  output wire        COMPENSATION_FILTER_EN,
  output wire        AUTO_LINE_FREQ_TRACK,
  output wire [23:0] CURRENT_OFFSET_TRIM,
  output wire [23:0] VOLTAGE_OFFSET_TRIM,
  output wire        ACTIVE_ENERGY_PULSE_OUT,
  output wire        SECOND_PULSE_OUT,
  output wire        THIRD_PULSE_OUT,
  output wire        COMPUTATION_DONE_FLAG,
  output wire        CAL_BUSY
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_AVG  = 4'h2;
  localparam [3:0] ST_PF   = 4'h4;
  localparam [3:0] ST_SQRT = 4'h8;

  reg [23:0] ioff_reg, voff_reg, mode_reg, temp_reg;
  reg [23:0] qmean_reg, qinst_reg, ipk_reg, vpk_reg;
  reg [23:0] qroot_reg, pfac_reg, s_reg, rdata_reg;
  reg [23:0] ipk_run_reg, vpk_run_reg, i_prev_reg, v_prev_reg;
  reg [23:0] i_path_reg, v_path_reg, p_hold_reg, samp_cnt_reg;
  reg [47:0] qsum_reg, num_reg, quo_reg;
  reg [48:0] rem_reg;
  reg [23:0] den_reg;
  reg [5:0]  step_reg;
  reg [3:0]  state_reg;
  reg        neg_reg, done_reg, cal_reg;
  reg [26:0] cal_cnt_reg;
  reg        pm_sync1_reg, pm_sync2_reg;
  reg        pls1_reg, pls2_reg, pls3_reg;

  reg [3:0]  state_next;
  reg [47:0] num_next, quo_next, quo_fin;
  reg [48:0] rem_next, rem_sh;
  reg [5:0]  step_next;
  reg [48:0] trial;

  function [23:0] mag;
    input [23:0] x;
    begin
      mag = x[23] ? (24'h000000 - x) : x;
    end
  endfunction

  // Saturates a magnitude to 23 bits and applies the sign.
  function [23:0] signed_sat;
    input [47:0] q;
    input        neg;
    reg   [22:0] m;
    begin
      m = (|q[47:23]) ? 23'h7FFFFF : q[22:0];
      signed_sat = neg ? (24'h000000 - {1'b0, m}) : {1'b0, m};
    end
  endfunction

  wire        wr_ioff = REG_WR && (REG_ADDR == `PMR_ADDR_IOFF);
  wire        wr_voff = REG_WR && (REG_ADDR == `PMR_ADDR_VOFF);
  wire        wr_mode = REG_WR && (REG_ADDR == `PMR_ADDR_MODE);
  wire        wr_stat = REG_WR && (REG_ADDR == `PMR_ADDR_STATUS);
  wire [23:0] n_eff = (CYCLE_COUNT == 24'h000000) ? 24'h000001 : CYCLE_COUNT;
  wire        last_samp = SAMPLE_VALID && CONVERTING && (samp_cnt_reg + 24'h000001 >= n_eff);

  wire signed [47:0] q_prod = $signed(I_SAMPLE) * $signed(V_QUAD_SAMPLE);
  wire [23:0] q_new = q_prod[46:23];
  wire [47:0] qsum_fin = qsum_reg + {{24{q_new[23]}}, q_new};
  wire [47:0] s_prod = V_RMS * I_RMS;
  wire [23:0] s_new = {1'b0, s_prod[47:25]};
  wire [23:0] p_mag = mag(p_hold_reg);
  wire [47:0] s_sq = s_reg * s_reg;
  wire [47:0] p_sq = p_mag * p_mag;
  wire [26:0] cal_len = `PMR_CAL_MUL * {3'h0, n_eff} + `PMR_CAL_ADD;
  wire        cal_end = cal_reg && SAMPLE_VALID && (cal_cnt_reg + 27'd1 >= cal_len);
  wire        calc_end = state_reg[3] && (step_reg == `PMR_SQRT_STEPS - 6'd1);
  wire [23:0] ipk_cand = (mag(I_SAMPLE) > mag(ipk_run_reg)) ? I_SAMPLE : ipk_run_reg;
  wire [23:0] vpk_cand = (mag(V_SAMPLE) > mag(vpk_run_reg)) ? V_SAMPLE : vpk_run_reg;

  // Shared iterative engine: divide for the average and power factor, root for trig power.
  always @* begin
    state_next = state_reg;
    num_next   = num_reg;
    quo_next   = quo_reg;
    quo_fin    = quo_reg;
    rem_next   = rem_reg;
    step_next  = step_reg + 6'd1;
    rem_sh     = {rem_reg[47:0], num_reg[47]};
    trial      = {23'h000000, quo_reg[23:0], 2'b01};
    case (state_reg)
      ST_IDLE: begin
        step_next = 6'd0;
        if (last_samp) begin
          state_next = ST_AVG;
          num_next   = qsum_fin[47] ? (48'h0 - qsum_fin) : qsum_fin;
          rem_next   = 49'h0;
          quo_next   = 48'h0;
        end
      end
      ST_AVG, ST_PF: begin
        num_next = {num_reg[46:0], 1'b0};
        if (rem_sh >= {25'h0, den_reg}) begin
          rem_next = rem_sh - {25'h0, den_reg};
          quo_fin  = {quo_reg[46:0], 1'b1};
        end else begin
          rem_next = rem_sh;
          quo_fin  = {quo_reg[46:0], 1'b0};
        end
        quo_next = quo_fin;
        if (step_reg == `PMR_DIV_STEPS - 6'd1) begin
          step_next  = 6'd0;
          rem_next   = 49'h0;
          quo_next   = 48'h0;
          if (state_reg[1]) begin
            state_next = ST_PF;
            num_next   = {1'b0, p_mag, 23'h000000};
          end else begin
            state_next = ST_SQRT;
            num_next   = (s_sq > p_sq) ? (s_sq - p_sq) : 48'h0;
          end
        end
      end
      ST_SQRT: begin
        rem_sh   = {rem_reg[46:0], num_reg[47:46]};
        num_next = {num_reg[45:0], 2'b00};
        if (rem_sh >= trial) begin
          rem_next = rem_sh - trial;
          quo_next = {quo_reg[46:0], 1'b1};
        end else begin
          rem_next = rem_sh;
          quo_next = {quo_reg[46:0], 1'b0};
        end
        if (calc_end) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= ST_IDLE;
      num_reg   <= 48'h0;
      quo_reg   <= 48'h0;
      rem_reg   <= 49'h0;
      step_reg  <= 6'd0;
      den_reg   <= 24'h000001;
      neg_reg   <= 1'b0;
      p_hold_reg <= `PMR_RST_RESULT;
      s_reg     <= `PMR_RST_RESULT;
      qmean_reg <= `PMR_RST_RESULT;
      pfac_reg  <= `PMR_RST_RESULT;
      qroot_reg <= `PMR_RST_RESULT;
    end else begin
      state_reg <= state_next;
      num_reg   <= num_next;
      quo_reg   <= quo_next;
      rem_reg   <= rem_next;
      step_reg  <= step_next;
      if (state_reg[0] && last_samp) begin
        den_reg    <= n_eff;
        neg_reg    <= qsum_fin[47];
        p_hold_reg <= P_ACTIVE;
        s_reg      <= s_new;
      end
      if (state_reg[1] && state_next[2]) begin
        qmean_reg <= signed_sat(quo_fin, neg_reg);
        den_reg  <= s_reg;
        neg_reg  <= p_hold_reg[23];
      end
      if (state_reg[2] && state_next[3]) begin
        pfac_reg <= signed_sat(quo_fin, neg_reg);
      end
      if (calc_end) begin
        qroot_reg <= {1'b0, quo_next[22:0]};
      end
    end
  end

  // Sample path: counting, peaks, instant reactive power, channel delays.
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      samp_cnt_reg <= 24'h000000;
      qsum_reg     <= 48'h0;
      qinst_reg    <= `PMR_RST_RESULT;
      ipk_run_reg  <= 24'h000000;
      vpk_run_reg  <= 24'h000000;
      ipk_reg      <= `PMR_RST_RESULT;
      vpk_reg      <= `PMR_RST_RESULT;
      i_prev_reg   <= 24'h000000;
      v_prev_reg   <= 24'h000000;
      i_path_reg   <= 24'h000000;
      v_path_reg   <= 24'h000000;
      temp_reg     <= `PMR_RST_RESULT;
    end else begin
      if (TEMP_VALID && CONVERTING) begin
        temp_reg <= TEMP_SAMPLE;
      end
      if (SAMPLE_VALID) begin
        i_prev_reg <= I_SAMPLE;
        v_prev_reg <= V_SAMPLE;
        i_path_reg <= mode_reg[`PMR_BIT_IDLY] ? i_prev_reg : I_SAMPLE;
        v_path_reg <= mode_reg[`PMR_BIT_VDLY] ? v_prev_reg : V_SAMPLE;
      end
      if (SAMPLE_VALID && CONVERTING) begin
        qinst_reg <= q_new;
        if (last_samp) begin
          samp_cnt_reg <= 24'h000000;
          qsum_reg     <= 48'h0;
          ipk_reg      <= ipk_cand;
          vpk_reg      <= vpk_cand;
          ipk_run_reg  <= 24'h000000;
          vpk_run_reg  <= 24'h000000;
        end else begin
          samp_cnt_reg <= samp_cnt_reg + 24'h000001;
          qsum_reg     <= qsum_fin;
          ipk_run_reg  <= ipk_cand;
          vpk_run_reg  <= vpk_cand;
        end
      end
    end
  end

  // Host registers, offset calibration and the computation-done flag.
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ioff_reg    <= `PMR_RST_OFFSET;
      voff_reg    <= `PMR_RST_OFFSET;
      mode_reg    <= `PMR_RST_MODE;
      cal_reg     <= 1'b0;
      cal_cnt_reg <= 27'd0;
      done_reg    <= 1'b0;
      rdata_reg   <= 24'h000000;
    end else begin
      if (wr_ioff) begin
        ioff_reg <= REG_WDATA;
      end
      if (wr_voff) begin
        voff_reg <= REG_WDATA;
      end
      if (wr_mode) begin
        mode_reg <= REG_WDATA & `PMR_MODE_MASK;
      end
      if (CAL_START && !cal_reg) begin
        cal_reg     <= 1'b1;
        cal_cnt_reg <= 27'd0;
      end else if (cal_end) begin
        cal_reg  <= 1'b0;
        ioff_reg <= 24'h000000 - {1'b0, I_RMS[23:1]};
        voff_reg <= 24'h000000 - {1'b0, V_RMS[23:1]};
      end else if (cal_reg && SAMPLE_VALID) begin
        cal_cnt_reg <= cal_cnt_reg + 27'd1;
      end
      if (cal_end || calc_end) begin
        done_reg <= 1'b1;
      end else if (wr_stat && REG_WDATA[`PMR_BIT_DONE]) begin
        done_reg <= 1'b0;
      end
      if (REG_RD) begin
        case (REG_ADDR)
          `PMR_ADDR_IOFF:   rdata_reg <= ioff_reg;
          `PMR_ADDR_VOFF:   rdata_reg <= voff_reg;
          `PMR_ADDR_MODE:   rdata_reg <= mode_reg;
          `PMR_ADDR_TEMP:   rdata_reg <= temp_reg;
          `PMR_ADDR_QMEAN:  rdata_reg <= qmean_reg;
          `PMR_ADDR_QINST:  rdata_reg <= qinst_reg;
          `PMR_ADDR_IPEAK:  rdata_reg <= ipk_reg;
          `PMR_ADDR_VPEAK:  rdata_reg <= vpk_reg;
          `PMR_ADDR_QROOT:  rdata_reg <= qroot_reg;
          `PMR_ADDR_PFAC:   rdata_reg <= pfac_reg;
          `PMR_ADDR_SAPP:   rdata_reg <= s_reg;
          `PMR_ADDR_STATUS: rdata_reg <= {done_reg, 23'h000000};
          default:          rdata_reg <= 24'h000000;
        endcase
      end
    end
  end

  // Pulse output selection; the supply monitor pin is synchronised first.
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      pm_sync1_reg <= 1'b0;
      pm_sync2_reg <= 1'b0;
      pls1_reg     <= 1'b0;
      pls2_reg     <= 1'b0;
      pls3_reg     <= 1'b0;
    end else begin
      pm_sync1_reg <= SUPPLY_MONITOR_INPUT;
      pm_sync2_reg <= pm_sync1_reg;
      pls1_reg <= ENERGY_PULSE_IN && !(mode_reg[`PMR_BIT_POS] && ENERGY_NEGATIVE);
      pls2_reg <= mode_reg[`PMR_BIT_E2SEL] ? APPARENT_PULSE_IN : ENERGY_NEGATIVE;
      case (mode_reg[`PMR_BIT_E3HI:`PMR_BIT_E3LO])
        2'b00:   pls3_reg <= REACTIVE_PULSE_IN;
        2'b01:   pls3_reg <= pm_sync2_reg;
        2'b10:   pls3_reg <= VOLTAGE_SIGN;
        default: pls3_reg <= APPARENT_PULSE_IN;
      endcase
    end
  end

  assign REG_RDATA               = rdata_reg;
  assign I_PATH_OUT              = i_path_reg;
  assign V_PATH_OUT              = v_path_reg;
  assign CURRENT_HIGHPASS_ENABLE = mode_reg[`PMR_BIT_IHP];
  assign VOLTAGE_HIGHPASS_ENABLE = mode_reg[`PMR_BIT_VHP];
  assign CURRENT_ALLPASS_ENABLE  = mode_reg[`PMR_BIT_VHP] & ~mode_reg[`PMR_BIT_IHP];
  assign VOLTAGE_ALLPASS_ENABLE  = mode_reg[`PMR_BIT_IHP] & ~mode_reg[`PMR_BIT_VHP];
  assign COMPENSATION_FILTER_EN  = ~mode_reg[`PMR_BIT_CBYP];
  assign AUTO_LINE_FREQ_TRACK    = mode_reg[`PMR_BIT_FTRK];
  assign CURRENT_OFFSET_TRIM     = ioff_reg;
  assign VOLTAGE_OFFSET_TRIM     = voff_reg;
  assign ACTIVE_ENERGY_PULSE_OUT = pls1_reg;
  assign SECOND_PULSE_OUT        = pls2_reg;
  assign THIRD_PULSE_OUT         = pls3_reg;
  assign COMPUTATION_DONE_FLAG   = done_reg;
  assign CAL_BUSY                = cal_reg;

endmodule

`default_nettype wire

/* tb/pmr_host.sv */
// Host model that drives the register port of the result and mode bank.
// Assumes one CLOCK; strobes change only just after rising edges.
`timescale 1ns/100ps
`default_nettype none
module pmr_host (
  input  wire logic        clk,
  output var  logic [4:0]  addr,
  output var  logic        wr,
  output var  logic        rd,
  output var  logic [23:0] wdata
);
  initial begin
    {addr, wr, rd, wdata} = '0;
  end
  // Writes one word; a mode word never carries both delay bits.
  task wr_reg(input logic [4:0] a, input logic [23:0] d);
    begin
      @(posedge clk);
      addr  <= a;
      wdata <= (a == 5'h12 && d[7]) ? (d & 24'hFFFEFF) : d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
    end
  endtask
  // Issues one read strobe.
  task rd_reg(input logic [4:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* tb/pmr_regs_assertions.sv */
// Checker for the result and mode register bank.
// Bound to pmr_regs; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module pmr_regs_chk (
  input wire        CLOCK,
  input wire        RESET_N,
  input wire [4:0]  REG_ADDR,
  input wire        REG_WR,
  input wire        REG_RD,
  input wire [23:0] REG_WDATA,
  input wire [23:0] REG_RDATA,
  input wire        SAMPLE_VALID,
  input wire [23:0] I_SAMPLE,
  input wire [23:0] V_SAMPLE,
  input wire        ENERGY_PULSE_IN,
  input wire        ENERGY_NEGATIVE,
  input wire        APPARENT_PULSE_IN,
  input wire        REACTIVE_PULSE_IN,
  input wire        VOLTAGE_SIGN,
  input wire [23:0] I_PATH_OUT,
  input wire [23:0] V_PATH_OUT,
  input wire        CURRENT_HIGHPASS_ENABLE,
  input wire        VOLTAGE_HIGHPASS_ENABLE,
  input wire        CURRENT_ALLPASS_ENABLE,
  input wire        VOLTAGE_ALLPASS_ENABLE,
  input wire        COMPENSATION_FILTER_EN,
  input wire        AUTO_LINE_FREQ_TRACK,
  input wire        ACTIVE_ENERGY_PULSE_OUT,
  input wire        SECOND_PULSE_OUT,
  input wire        THIRD_PULSE_OUT,
  input wire        COMPUTATION_DONE_FLAG,
  input wire        CAL_BUSY
);
  reg  [9:0]  mode_q;
  reg  [23:0] prev_i;
  reg  [23:0] prev_v;
  // Shadow of the mode word and of the previous samples.
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_q <= 10'h000;
      prev_i <= 24'h000000;
      prev_v <= 24'h000000;
    end else begin
      if (REG_WR && REG_ADDR == 5'h12) mode_q <= REG_WDATA[9:0];
      if (SAMPLE_VALID) prev_i <= I_SAMPLE;
      if (SAMPLE_VALID) prev_v <= V_SAMPLE;
    end
  end
  wire        pls1_exp = ENERGY_PULSE_IN && !(mode_q[1] && ENERGY_NEGATIVE);
  wire        pls2_exp = mode_q[9] ? APPARENT_PULSE_IN : ENERGY_NEGATIVE;
  wire        pls3_exp = mode_q[3] ? (mode_q[2] ? APPARENT_PULSE_IN : VOLTAGE_SIGN) : REACTIVE_PULSE_IN;
  wire [23:0] ei = mode_q[7] ? prev_i : I_SAMPLE;
  wire [23:0] ev = mode_q[8] ? prev_v : V_SAMPLE;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  sequence s_run; RESET_N && $past(RESET_N); endsequence
  sequence s_rd_mode; REG_RD && REG_ADDR == 5'h12; endsequence
  sequence s_cal_end; $fell(CAL_BUSY); endsequence
  property p_iap; CURRENT_ALLPASS_ENABLE == (VOLTAGE_HIGHPASS_ENABLE && !CURRENT_HIGHPASS_ENABLE); endproperty
  a_iap: assert property (p_iap) else $error("current all-pass wrong");
  property p_vap; VOLTAGE_ALLPASS_ENABLE == (CURRENT_HIGHPASS_ENABLE && !VOLTAGE_HIGHPASS_ENABLE); endproperty
  a_vap: assert property (p_vap) else $error("voltage all-pass wrong");
  property p_hpf; {CURRENT_HIGHPASS_ENABLE, VOLTAGE_HIGHPASS_ENABLE} == mode_q[6:5]; endproperty
  a_hpf: assert property (p_hpf) else $error("high-pass enables wrong");
  property p_cfe; COMPENSATION_FILTER_EN == !mode_q[4]; endproperty
  a_cfe: assert property (p_cfe) else $error("compensation enable wrong");
  property p_afc; AUTO_LINE_FREQ_TRACK == mode_q[0]; endproperty
  a_afc: assert property (p_afc) else $error("line tracking enable wrong");
  property p_pls1; s_run |-> ACTIVE_ENERGY_PULSE_OUT == $past(pls1_exp); endproperty
  a_pls1: assert property (p_pls1) else $error("first pulse output wrong");
  property p_pls2; s_run |-> SECOND_PULSE_OUT == $past(pls2_exp); endproperty
  a_pls2: assert property (p_pls2) else $error("second pulse output wrong");
  property p_pls3; s_run |-> ($past(mode_q[3:2]) == 2'b01) || (THIRD_PULSE_OUT == $past(pls3_exp)); endproperty
  a_pls3: assert property (p_pls3) else $error("third pulse output wrong");
  property p_ipath; SAMPLE_VALID |=> I_PATH_OUT == $past(ei); endproperty
  a_ipath: assert property (p_ipath) else $error("current path delay wrong");
  property p_vpath; SAMPLE_VALID |=> V_PATH_OUT == $past(ev); endproperty
  a_vpath: assert property (p_vpath) else $error("voltage path delay wrong");
  property p_rdm; s_rd_mode |=> REG_RDATA == {14'h0000, $past(mode_q)}; endproperty
  a_rdm: assert property (p_rdm) else $error("mode readback wrong");
  property p_cal; s_cal_end |-> COMPUTATION_DONE_FLAG; endproperty
  a_cal: assert property (p_cal) else $error("done flag not set at calibration end");
  property p_stk; REG_WR && REG_ADDR == 5'h0F && !REG_WDATA[23] && COMPUTATION_DONE_FLAG |=> COMPUTATION_DONE_FLAG;
  endproperty
  a_stk: assert property (p_stk) else $error("done flag lost on zero write");
endmodule
bind pmr_regs pmr_regs_chk chk_u (.*);
`default_nettype wire

/* tb/pmr_regs_bench.sv */
// Self-checking bench for the result and mode register bank.
// Assumes pmr_regs, the host model and the bound checker are compiled.
`timescale 1ns/100ps
`default_nettype none
module pmr_regs_bench;
  logic        RESET_N, SAMPLE_VALID, CONVERTING, TEMP_VALID, CAL_START, CLOCK, rd_d;
  logic        ENERGY_PULSE_IN, ENERGY_NEGATIVE, APPARENT_PULSE_IN, REACTIVE_PULSE_IN;
  logic        VOLTAGE_SIGN, SUPPLY_MONITOR_INPUT, REG_WR, REG_RD;
  logic [4:0]  REG_ADDR;
  logic [23:0] REG_WDATA, CYCLE_COUNT, I_SAMPLE, V_SAMPLE, V_QUAD_SAMPLE, TEMP_SAMPLE, P_ACTIVE, I_RMS, V_RMS;
  logic [23:0] d, m;
  wire  [23:0] REG_RDATA, I_PATH_OUT, V_PATH_OUT, CURRENT_OFFSET_TRIM, VOLTAGE_OFFSET_TRIM;
  wire         CURRENT_HIGHPASS_ENABLE, VOLTAGE_HIGHPASS_ENABLE, CURRENT_ALLPASS_ENABLE;
  wire         VOLTAGE_ALLPASS_ENABLE, COMPENSATION_FILTER_EN, AUTO_LINE_FREQ_TRACK;
  wire         ACTIVE_ENERGY_PULSE_OUT, SECOND_PULSE_OUT, THIRD_PULSE_OUT, COMPUTATION_DONE_FLAG, CAL_BUSY;
  int          err_count, samples_checked, seed, k, r;
  logic [23:0] eq[$];
  logic [4:0]  aq[$];
  logic [4:0]  ra[5] = '{5'h10, 5'h11, 5'h12, 5'h1A, 5'h0F};
  logic [23:0] si[4] = '{24'h100000, 24'hD00000, 24'h200000, 24'h400000};
  logic [23:0] sv[4] = '{24'h200000, 24'h100000, 24'hA00000, 24'h300000};
  pmr_regs dut_u (.*);
  pmr_host host_u (.clk(CLOCK), .addr(REG_ADDR), .wr(REG_WR), .rd(REG_RD), .wdata(REG_WDATA));
  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end
  task check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    begin
      samples_checked++;
      if (seen !== exp) begin
        err_count++;
        $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // Notes the expected word, then reads it.
  task rx(input logic [4:0] a, input logic [23:0] e);
    begin
      aq.push_back(a);
      eq.push_back(e);
      host_u.rd_reg(a);
    end
  endtask
  task smp(input logic [23:0] i, input logic [23:0] v);
    begin
      @(posedge CLOCK);
      I_SAMPLE <= i;
      V_SAMPLE <= v;
      SAMPLE_VALID <= 1'b1;
      @(posedge CLOCK);
      SAMPLE_VALID <= 1'b0;
    end
  endtask
  task tpulse(input logic [23:0] t);
    begin
      @(posedge CLOCK);
      TEMP_SAMPLE <= t;
      TEMP_VALID <= 1'b1;
      @(posedge CLOCK);
      TEMP_VALID <= 1'b0;
    end
  endtask
  task stop_test;
    begin
      $display("compared %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Read results are compared against the oldest note.
  always @(posedge CLOCK) rd_d <= REG_RD;
  always @(negedge CLOCK) if (rd_d === 1'b1) check($sformatf("reg %h", aq.pop_front()), REG_RDATA, eq.pop_front());
  initial begin
    #400000;
    err_count++;
    stop_test;
  end
  initial begin
    {RESET_N, SAMPLE_VALID, CONVERTING, TEMP_VALID, CAL_START, ENERGY_PULSE_IN, ENERGY_NEGATIVE} = '0;
    {APPARENT_PULSE_IN, REACTIVE_PULSE_IN, VOLTAGE_SIGN, SUPPLY_MONITOR_INPUT, CYCLE_COUNT, I_SAMPLE} = '0;
    {V_SAMPLE, TEMP_SAMPLE, P_ACTIVE, I_RMS, V_RMS} = '0;
    V_QUAD_SAMPLE = 24'h400000;
    seed = 15;
    repeat (16) @(posedge CLOCK);
    RESET_N <= 1'b1;
    foreach (ra[k]) rx(ra[k], 24'h000000);
    r = $random(seed);
    d = r[23:0];
    host_u.wr_reg(5'h10, d);
    host_u.wr_reg(5'h11, ~d);
    host_u.wr_reg(5'h13, d);
    rx(5'h10, d);
    rx(5'h11, ~d);
    rx(5'h13, 24'h000000);
    // One computation cycle of four conversions.
    CYCLE_COUNT <= 24'h000004;
    CONVERTING <= 1'b1;
    V_RMS <= 24'h500000;
    I_RMS <= 24'h200000;
    P_ACTIVE <= 24'h040000;
    for (k = 0; k < 4; k++) smp(si[k], sv[k]);
    repeat (130) @(posedge CLOCK);
    rx(5'h14, 24'h080000);
    rx(5'h15, 24'h200000);
    rx(5'h16, 24'h400000);
    rx(5'h17, 24'hA00000);
    rx(5'h1B, 24'h050000);
    rx(5'h18, 24'h030000);
    rx(5'h19, 24'h666666);
    rx(5'h0F, 24'h800000);
    host_u.wr_reg(5'h0F, 24'h000000);
    rx(5'h0F, 24'h800000);
    host_u.wr_reg(5'h0F, 24'h800000);
    rx(5'h0F, 24'h000000);
    tpulse(24'hE78000);
    CONVERTING <= 1'b0;
    tpulse(24'h123400);
    rx(5'h13, 24'hE78000);
    // Offset calibration with N of two.
    CYCLE_COUNT <= 24'h000002;
    @(posedge CLOCK);
    CAL_START <= 1'b1;
    @(posedge CLOCK);
    CAL_START <= 1'b0;
    @(negedge CLOCK);
    check("busy", {23'h0, CAL_BUSY}, 24'h000001);
    for (k = 0; k < 42; k++) begin
      if (k == 41) begin
        @(negedge CLOCK);
        check("busy", {23'h0, CAL_BUSY}, 24'h000001);
      end
      r = $random(seed);
      smp(r[23:0], {r[11:0], r[23:12]});
    end
    repeat (2) @(posedge CLOCK);
    @(negedge CLOCK);
    check("busy", {23'h0, CAL_BUSY}, 24'h000000);
    check("flag", {23'h0, COMPUTATION_DONE_FLAG}, 24'h000001);
    check("itrim", CURRENT_OFFSET_TRIM, 24'hF00000);
    check("vtrim", VOLTAGE_OFFSET_TRIM, 24'hD80000);
    // Random mode words with random pulse inputs and samples.
    CONVERTING <= 1'b1;
    CYCLE_COUNT <= 24'h0003E8;
    for (k = 0; k < 40; k++) begin
      r = $random(seed);
      host_u.wr_reg(5'h12, r[23:0]);
      m = r[23:0] & 24'h0003FF;
      if (m[7]) m[8] = 1'b0;
      rx(5'h12, m);
      repeat (6) begin
        @(posedge CLOCK);
        r = $random(seed);
        {ENERGY_PULSE_IN, ENERGY_NEGATIVE, APPARENT_PULSE_IN, REACTIVE_PULSE_IN, VOLTAGE_SIGN} <= r[4:0];
        I_SAMPLE <= r[23:0];
        V_SAMPLE <= r[31:8];
        SAMPLE_VALID <= ~SAMPLE_VALID;
      end
    end
    host_u.wr_reg(5'h12, 24'h000004);
    repeat (4) @(posedge CLOCK);
    @(negedge CLOCK);
    check("third", {23'h0, THIRD_PULSE_OUT}, 24'h000000);
    @(posedge CLOCK);
    SUPPLY_MONITOR_INPUT <= 1'b1;
    repeat (6) @(posedge CLOCK);
    @(negedge CLOCK);
    check("third", {23'h0, THIRD_PULSE_OUT}, 24'h000001);
    repeat (4) @(posedge CLOCK);
    stop_test;
  end
endmodule
`default_nettype wire
